// ==== hdl/lcd_drive_reset_control.sv ====
// segment lcd drive control with reset handling and axi4-lite registers
// Operation
// - lcd reset is display-off or sleep (or mcu reset)
// - enable low outside reset and sleep: lcd reset, all outputs low
// - sleep resets lcd and drives outputs low even when enabled
// - mcu reset resets lcd and floats all outputs while it lasts
// - watchdog time-out during idle or sleep is no mcu reset here
// - a frame has one time slot per common line in use
// - waveform type bit picks type a or type b drive
// - type b waveforms run at lower frequency than type a
// - every pixel sees zero net dc across a full frame cycle
// - 1/2-bias levels in both three-com and two-com modes
// - display enable clears at power-on so display starts off
// - duty bit 0 gives three coms, 1 two coms; third com becomes segment
// - lcd clock is sub oscillator divided by eight
// - memory bit 1 lights pixel, 0 blanks it, read continuously
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "lcd_drive_cfg.svh"

module lcd_drive_reset_control
    import lcd_drive_pkg::*;
#(
    parameter int SEG_PINS  = `LCD_SEG_PINS,
    parameter int MEM_WORDS = `LCD_MEM_WORDS,
    parameter int SUB_DIV   = `LCD_SUB_DIV
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   subOscClock,
    input  wire logic                   mcuResetReq,
    input  wire logic                   wdtTimeoutReq,
    input  wire logic                   idleMode,
    input  wire logic                   sleepMode,
    input  wire logic [`LCD_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [`LCD_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    output level_t [`LCD_COM_PINS-1:0]  comLevel,
    output level_t [SEG_PINS-1:0]       segLevel,
    output logic                        driveEn,
    output logic                        pumpEn
);

    localparam int         ADDR_W   = `LCD_ADDR_W;
    localparam int         COM_PINS = `LCD_COM_PINS;
    localparam int         WORD_W   = ADDR_W - 2;
    localparam logic [7:0] CTRL_RST = `CTRL_RESET_VAL;

    if (MEM_WORDS != SEG_PINS + 1 || SEG_PINS < 1 ||
        (`REG_DMEM_OFS >> 2) + MEM_WORDS > (1 << WORD_W))
    begin : badSize
        $error("lcd_drive_reset_control: memory size does not fit the pins");
    end

    typedef struct packed {
        logic                                waveType;
        logic                                pumpEn;
        logic                                dutySelect;
        logic                                displayOnCtl;
        logic [MEM_WORDS-1:0][COM_PINS-1:0]  dispMem;
        logic [1:0]                          slot;
        logic                                phase;
        logic                                frameInv;
        level_t [COM_PINS-1:0]               comLevel;
        level_t [SEG_PINS-1:0]               segLevel;
        logic                                driveEn;
        logic                                awTaken;
        logic [ADDR_W-1:0]                   awAddr;
        logic                                wTaken;
        logic [7:0]                          wByte;
        logic                                wLane;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [31:0]                         rdata;
        logic [1:0]                          rresp;
    } state_t;

    state_t     state_r;
    state_t     state_nxt;
    logic [1:0] rstPipe_r;
    logic       rstN;
    logic       lcdTick;
    logic       mcuHold;
    logic       lcdReset;
    logic [1:0] lastSlot;
    logic       polarity;

    // register decode shared by read and write paths
    function automatic reg_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
        logic [WORD_W-1:0] word;
        word = addr[ADDR_W-1:2];
        if (word == WORD_W'(`REG_CTRL_OFS >> 2))
            return SEL_CTRL;
        else if (word == WORD_W'(`REG_STATUS_OFS >> 2))
            return SEL_STATUS;
        else if (word >= WORD_W'(`REG_DMEM_OFS >> 2) &&
                 word <  WORD_W'((`REG_DMEM_OFS >> 2) + MEM_WORDS))
            return SEL_DMEM;
        else
            return SEL_NONE;
    endfunction

    function automatic logic [WORD_W-1:0] dmemIndex(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2] - WORD_W'(`REG_DMEM_OFS >> 2);
    endfunction

    // level of a segment pin: lit pixels oppose the active com level
    function automatic level_t segDrive(input logic lit, input logic pol);
        if (lit ^ pol)
            return LVL_LOW;
        else
            return LVL_HIGH;
    endfunction

    function automatic state_t resetState();
        state_t st;
        st              = '0;
        st.waveType     = CTRL_RST[`CTRL_TYPE_BIT];
        st.pumpEn       = CTRL_RST[`CTRL_PUMP_BIT];
        st.dutySelect   = CTRL_RST[`CTRL_DUTY_BIT];
        st.displayOnCtl = CTRL_RST[`CTRL_ENABLE_BIT];
        for (int i = 0; i < COM_PINS; i++)
            st.comLevel[i] = LVL_LOW;
        for (int i = 0; i < SEG_PINS; i++)
            st.segLevel[i] = LVL_LOW;
        st.bresp = `AXI_RESP_OKAY;
        st.rresp = `AXI_RESP_OKAY;
        return st;
    endfunction

    localparam state_t STATE_RST = resetState();

    // reset: asynchronous assertion, release through two flops
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rstPipe_r <= 2'h0;
        else
            rstPipe_r <= {rstPipe_r[0], 1'b1};
    end

    assign rstN = rstPipe_r[1];

    lcd_clock_divider #(
        .SUB_DIV     (SUB_DIV)
    ) clockDivider (
        .clk_sys     (clk_sys),
        .rstN        (rstN),
        .subOscClock (subOscClock),
        .lcdTick     (lcdTick)
    );

    // watchdog time-out in low-power modes does not count
    assign mcuHold  = mcuResetReq | (wdtTimeoutReq & ~(idleMode | sleepMode));
    assign lcdReset = ~state_r.displayOnCtl | sleepMode | mcuHold;
    assign lastSlot = state_r.dutySelect ? `LCD_SLOTS_HALF - 2'h1
                                         : `LCD_SLOTS_THIRD - 2'h1;
    // type a inverts every half slot, type b every frame
    assign polarity = state_r.waveType ? state_r.frameInv : state_r.phase;

    always_comb
    begin
        reg_sel_t          wSel;
        reg_sel_t          rSel;
        logic [WORD_W-1:0] wIdx;
        logic [WORD_W-1:0] rIdx;
        logic [COM_PINS-1:0] memWord;
        wSel      = decodeSel(state_r.awAddr);
        rSel      = decodeSel(araddr);
        wIdx      = dmemIndex(state_r.awAddr);
        rIdx      = dmemIndex(araddr);
        memWord   = '0;
        state_nxt = state_r;

        // write address and data, taken in either order
        if (awvalid && awready)
        begin
            state_nxt.awTaken = 1'b1;
            state_nxt.awAddr  = awaddr;
        end
        if (wvalid && wready)
        begin
            state_nxt.wTaken = 1'b1;
            state_nxt.wByte  = wdata[7:0];
            state_nxt.wLane  = wstrb[0];
        end
        if (state_r.bvalid && bready)
            state_nxt.bvalid = 1'b0;

        if (state_r.awTaken && state_r.wTaken && !state_r.bvalid)
        begin
            state_nxt.awTaken = 1'b0;
            state_nxt.wTaken  = 1'b0;
            state_nxt.bvalid  = 1'b1;
            state_nxt.bresp   = `AXI_RESP_OKAY;
            case (wSel)
                SEL_CTRL:
                begin
                    if (state_r.wLane)
                    begin
                        state_nxt.waveType     = state_r.wByte[`CTRL_TYPE_BIT];
                        state_nxt.pumpEn       = state_r.wByte[`CTRL_PUMP_BIT];
                        state_nxt.dutySelect   = state_r.wByte[`CTRL_DUTY_BIT];
                        state_nxt.displayOnCtl = state_r.wByte[`CTRL_ENABLE_BIT];
                    end
                end
                SEL_STATUS:
                begin
                    state_nxt.bresp = `AXI_RESP_OKAY;
                end
                SEL_DMEM:
                begin
                    if (state_r.wLane)
                        state_nxt.dispMem[wIdx] = state_r.wByte[COM_PINS-1:0];
                end
                default:
                begin
                    state_nxt.bresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        // read channel
        if (state_r.rvalid && rready)
            state_nxt.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata  = '0;
            state_nxt.rresp  = `AXI_RESP_OKAY;
            case (rSel)
                SEL_CTRL:
                begin
                    state_nxt.rdata[`CTRL_TYPE_BIT]   = state_r.waveType;
                    state_nxt.rdata[`CTRL_PUMP_BIT]   = state_r.pumpEn;
                    state_nxt.rdata[`CTRL_DUTY_BIT]   = state_r.dutySelect;
                    state_nxt.rdata[`CTRL_ENABLE_BIT] = state_r.displayOnCtl;
                end
                SEL_STATUS:
                begin
                    state_nxt.rdata[`STAT_RESET_BIT]                 = lcdReset;
                    state_nxt.rdata[`STAT_DRIVE_BIT]                 = state_r.driveEn;
                    state_nxt.rdata[`STAT_SLOT_LSB+1:`STAT_SLOT_LSB] = state_r.slot;
                    state_nxt.rdata[`STAT_POL_BIT]                   = polarity;
                end
                SEL_DMEM:
                begin
                    memWord = state_r.dispMem[rIdx];
                    // the third com bit reads zero in half duty
                    if (state_r.dutySelect)
                        memWord[COM_PINS-1] = 1'b0;
                    state_nxt.rdata[COM_PINS-1:0] = memWord;
                end
                default:
                begin
                    state_nxt.rresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        // frame timing
        if (lcdReset)
        begin
            state_nxt.slot     = 2'h0;
            state_nxt.phase    = 1'b0;
            state_nxt.frameInv = 1'b0;
        end
        else if (lcdTick)
        begin
            if (!state_r.waveType && !state_r.phase)
            begin
                state_nxt.phase = 1'b1;
            end
            else
            begin
                state_nxt.phase = 1'b0;
                if (state_r.slot >= lastSlot)
                begin
                    state_nxt.slot     = 2'h0;
                    state_nxt.frameInv = ~state_r.frameInv;
                end
                else
                begin
                    state_nxt.slot = state_r.slot + 2'h1;
                end
            end
        end

        // pin levels
        if (mcuHold)
        begin
            state_nxt.driveEn = 1'b0;
            for (int i = 0; i < COM_PINS; i++)
                state_nxt.comLevel[i] = LVL_LOW;
            for (int i = 0; i < SEG_PINS; i++)
                state_nxt.segLevel[i] = LVL_LOW;
        end
        else if (lcdReset)
        begin
            state_nxt.driveEn = 1'b1;
            for (int i = 0; i < COM_PINS; i++)
                state_nxt.comLevel[i] = LVL_LOW;
            for (int i = 0; i < SEG_PINS; i++)
                state_nxt.segLevel[i] = LVL_LOW;
        end
        else
        begin
            state_nxt.driveEn = 1'b1;
            for (int c = 0; c < COM_PINS; c++)
            begin
                if (2'(c) == state_r.slot)
                    state_nxt.comLevel[c] = polarity ? LVL_LOW : LVL_HIGH;
                else
                    state_nxt.comLevel[c] = LVL_MID;
            end
            for (int s = 0; s < SEG_PINS; s++)
                state_nxt.segLevel[s] = segDrive(state_r.dispMem[s][state_r.slot], polarity);
            if (state_r.dutySelect)
                state_nxt.comLevel[COM_PINS-1] =
                    segDrive(state_r.dispMem[MEM_WORDS-1][state_r.slot], polarity);
        end
    end

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            state_r <= STATE_RST;
        else
            state_r <= state_nxt;
    end

    // bus handshakes
    assign awready  = ~state_r.awTaken & ~state_r.bvalid;
    assign wready   = ~state_r.wTaken & ~state_r.bvalid;
    assign arready  = ~state_r.rvalid;
    assign bvalid   = state_r.bvalid;
    assign bresp    = state_r.bresp;
    assign rvalid   = state_r.rvalid;
    assign rdata    = state_r.rdata;
    assign rresp    = state_r.rresp;

    // pin outputs
    assign comLevel = state_r.comLevel;
    assign segLevel = state_r.segLevel;
    assign driveEn  = state_r.driveEn;
    assign pumpEn   = state_r.pumpEn;

endmodule // lcd_drive_reset_control

// ==== hdl/lcd_drive_cfg.svh ====
// constants for the segment lcd drive block
`ifndef LCD_DRIVE_CFG_SVH
`define LCD_DRIVE_CFG_SVH

`define LCD_SUB_DIV        8
`define LCD_SEG_PINS       21
`define LCD_MEM_WORDS      22
`define LCD_COM_PINS       3
`define LCD_SLOTS_THIRD    2'h3
`define LCD_SLOTS_HALF     2'h2
`define LCD_ADDR_W         8

`define REG_CTRL_OFS       8'h00
`define REG_STATUS_OFS     8'h04
`define REG_DMEM_OFS       8'h40

`define CTRL_TYPE_BIT      7
`define CTRL_PUMP_BIT      2
`define CTRL_DUTY_BIT      1
`define CTRL_ENABLE_BIT    0
`define CTRL_RESET_VAL     8'h00

`define STAT_RESET_BIT     0
`define STAT_DRIVE_BIT     1
`define STAT_SLOT_LSB      2
`define STAT_POL_BIT       4

`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// ==== hdl/lcd_drive_pkg.sv ====
// types shared by the segment lcd drive block
package lcd_drive_pkg;

    // the three 1/2-bias drive levels of a com or seg pin
    typedef enum logic [1:0] {
        LVL_LOW,
        LVL_MID,
        LVL_HIGH
    } level_t;

    // register decode result
    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_STATUS,
        SEL_DMEM,
        SEL_NONE
    } reg_sel_t;

endpackage

// ==== hdl/lcd_clock_divider.sv ====
// lcd timing tick from the synchronised sub oscillator clock
`timescale 1ns/1ns
`include "lcd_drive_cfg.svh"

module lcd_clock_divider
    import lcd_drive_pkg::*;
#(
    parameter int SUB_DIV = `LCD_SUB_DIV
)
(
    input  wire logic clk_sys,
    input  wire logic rstN,
    input  wire logic subOscClock,
    output logic      lcdTick
);

    localparam int CNT_W = (SUB_DIV > 2) ? $clog2(SUB_DIV) : 1;

    if (SUB_DIV < 2)
    begin : badDiv
        $error("lcd_clock_divider: SUB_DIV must be at least 2");
    end

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             sync3;
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } div_state_t;

    div_state_t divState_r;
    div_state_t divState_nxt;

    // one tick per SUB_DIV rising edges of the sub oscillator
    always_comb
    begin
        divState_nxt       = divState_r;
        divState_nxt.sync1 = subOscClock;
        divState_nxt.sync2 = divState_r.sync1;
        divState_nxt.sync3 = divState_r.sync2;
        divState_nxt.tick  = 1'b0;
        if (divState_r.sync2 && !divState_r.sync3)
        begin
            if (divState_r.cnt == CNT_W'(SUB_DIV - 1))
            begin
                divState_nxt.cnt  = '0;
                divState_nxt.tick = 1'b1;
            end
            else
            begin
                divState_nxt.cnt = divState_r.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            divState_r <= '0;
        else
            divState_r <= divState_nxt;
    end

    assign lcdTick = divState_r.tick;

endmodule // lcd_clock_divider

// ==== test/lcd_drive_chk.sv ====
// port assertions for the segment lcd drive block
`timescale 1ns/1ns
`include "lcd_drive_cfg.svh"

module lcd_drive_chk
    import lcd_drive_pkg::*;
#(
    parameter int SEG_PINS = 21
)
(
    input logic                         clk_sys,
    input logic                         reset_n,
    input logic                         mcuResetReq,
    input logic                         wdtTimeoutReq,
    input logic                         idleMode,
    input logic                         sleepMode,
    input level_t [`LCD_COM_PINS-1:0]   comLevel,
    input level_t [SEG_PINS-1:0]        segLevel,
    input logic                         driveEn
);
    logic [2:0]            settleCnt;
    logic                  settled;
    logic                  allLow;
    logic                  badLevel;
    logic [2*SEG_PINS+5:0] flatLvl;

    assign flatLvl = {comLevel, segLevel};
    assign allLow  = (flatLvl == '0);
    assign settled = (settleCnt == 3'h7);

    always_comb
    begin
        badLevel = 1'b0;
        for (int i = 0; i < SEG_PINS + 3; i++)
            badLevel = badLevel | (flatLvl[2*i+:2] == 2'h3);
    end

    // masks the reset synchroniser window after release
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            settleCnt <= 3'h0;
        else if (!settled)
            settleCnt <= settleCnt + 3'h1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence quietSleep;
        settled && sleepMode && !mcuResetReq;
    endsequence
    sequence wdtRun;
        wdtTimeoutReq && !idleMode && !sleepMode;
    endsequence

    a_mcu_float: assert property (mcuResetReq |=> !driveEn)
        else $error("outputs driven during mcu reset");
    a_wdt_run: assert property (wdtRun |=> !driveEn)
        else $error("watchdog reset in run mode did not float outputs");
    a_float_low: assert property (!driveEn [*2] |-> allLow)
        else $error("levels not low while floating");
    a_wdt_asleep: assert property (settled && wdtTimeoutReq && (idleMode || sleepMode)
        && !mcuResetReq && !$past(mcuResetReq) |=> driveEn) else $error("low power watchdog floated outputs");
    a_sleep_low: assert property (quietSleep [*3] |-> allLow && driveEn)
        else $error("sleep did not drive all outputs low");
    a_one_com: assert property (comLevel[0] == LVL_HIGH |-> comLevel[1] == LVL_MID)
        else $error("two commons active in one slot");
    a_level_code: assert property (!badLevel)
        else $error("illegal drive level code");
    a_restart: assert property ($past(allLow) && !allLow |-> comLevel[0] == LVL_HIGH)
        else $error("frame did not restart at first common slot");
endmodule // lcd_drive_chk

bind lcd_drive_reset_control lcd_drive_chk #(.SEG_PINS(SEG_PINS)) chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .mcuResetReq(mcuResetReq), .wdtTimeoutReq(wdtTimeoutReq), .idleMode(idleMode), .sleepMode(sleepMode),
    .comLevel(comLevel), .segLevel(segLevel), .driveEn(driveEn));

// ==== test/lcd_glass_model.sv ====
// glass panel model: integrates pixel voltage for coms 0..2 and segs 0..1
`timescale 1ns/1ns

module lcd_glass_model
    import lcd_drive_pkg::*;
#(
    parameter int SEG_PINS = 21
)
(
    input logic                   clk_sys,
    input level_t [2:0]           comLevel,
    input level_t [SEG_PINS-1:0]  segLevel,
    input logic                   driveEn,
    input logic                   clearSums,
    output int                    dcSum [3][2],
    output int                    fullCnt [3][2]
);
    // pixel voltage in half-bias steps, com minus seg
    function automatic int pixelV(input int c, input int s);
        return int'(comLevel[c]) - int'(segLevel[s]);
    endfunction

    // floating pins leave the pixel undefined, so nothing is integrated then
    always @(posedge clk_sys)
    begin
        for (int c = 0; c < 3; c++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (clearSums)
                begin
                    dcSum[c][s] <= 0;
                    fullCnt[c][s] <= 0;
                end
                else if (driveEn)
                begin
                    dcSum[c][s] <= dcSum[c][s] + pixelV(c, s);
                    if (pixelV(c, s) == 2 || pixelV(c, s) == -2)
                        fullCnt[c][s] <= fullCnt[c][s] + 1;
                end
            end
        end
    end
endmodule // lcd_glass_model

// ==== test/testbench.sv ====
// self-checking bench for the segment lcd drive block
`timescale 1ns/1ns
`include "lcd_drive_cfg.svh"
`define CHECK(got, exp) \
    begin \
        testsRun++; \
        if ((got) !== (exp)) \
        begin \
            errorCnt++; \
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end

module testbench
    import lcd_drive_pkg::*;
;
    localparam int SEG_N = `LCD_SEG_PINS;
    localparam int DIV   = `LCD_SUB_DIV;
    localparam int WIN   = 3072;
    logic clk_sys = 1'b0;
    logic reset_n, subOscClock, mcuResetReq, wdtTimeoutReq, idleMode, sleepMode, clearSums;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, driveEn, pumpEn;
    level_t [2:0] comLevel;
    level_t [SEG_N-1:0] segLevel;
    level_t prevLvl;
    int dcSum [3][2];
    int fullCnt [3][2];
    int errorCnt, testsRun, cnt, e;
    logic [31:0] rng = 32'h24;

    always #5 clk_sys = ~clk_sys;
    always #40 subOscClock = ~subOscClock;

    lcd_drive_reset_control #(.SUB_DIV(DIV)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .subOscClock(subOscClock), .mcuResetReq(mcuResetReq), .wdtTimeoutReq(wdtTimeoutReq),
        .idleMode(idleMode), .sleepMode(sleepMode), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .comLevel(comLevel), .segLevel(segLevel), .driveEn(driveEn), .pumpEn(pumpEn));

    lcd_glass_model #(.SEG_PINS(SEG_N)) glass_u (.clk_sys(clk_sys), .comLevel(comLevel),
        .segLevel(segLevel), .driveEn(driveEn), .clearSums(clearSums), .dcSum(dcSum), .fullCnt(fullCnt));

    function automatic logic [31:0] nextRand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic [31:0] ctrlWord(input logic typeB, input logic half, input logic en);
        return {24'h0, typeB, 4'h0, 1'b1, half, en};
    endfunction

    // unlit segment toggles every tick in type a, once per frame in type b
    function automatic int expChanges(input logic typeB, input logic half);
        int ticks;
        ticks = WIN / (DIV * 8);
        return typeB ? ticks / (half ? 2 : 3) : ticks;
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic wdtPulse();
        @(posedge clk_sys);
        wdtTimeoutReq <= 1'b1;
        @(posedge clk_sys);
        wdtTimeoutReq <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic completeRun();
        $display("errors %0d checks %0d", errorCnt, testsRun);
        if (errorCnt == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        errorCnt++;
        $display("MISMATCH at %0t: run did not finish", $time);
        completeRun();
    end

    initial
    begin
        {reset_n, subOscClock, mcuResetReq, wdtTimeoutReq, idleMode, sleepMode, clearSums} = '0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        settle(4);
        `CHECK({driveEn, pumpEn}, 2'h2)
        `CHECK({comLevel, segLevel}, '0)
        axiRead(`REG_CTRL_OFS, rd, resp);
        `CHECK(rd, 32'h0)
        axiRead(`REG_STATUS_OFS, rd, resp);
        `CHECK(rd[`STAT_RESET_BIT], 1'b1)
        for (int i = 0; i < `LCD_MEM_WORDS; i++)
            axiWrite(`REG_DMEM_OFS + 8'(4 * i), nextRand() & 32'h7, resp);
        axiWrite(`REG_DMEM_OFS, 32'h1, resp);
        axiWrite(`REG_DMEM_OFS + 8'h04, 32'h0, resp);
        axiRead(8'h20, rd, resp);
        `CHECK(resp, `AXI_RESP_SLVERR)
        for (int m = 0; m < 4; m++)
        begin
            axiWrite(`REG_CTRL_OFS, ctrlWord(m[1], m[0], 1'b1), resp);
            repeat (256) @(posedge clk_sys);
            clearSums <= 1'b1;
            @(posedge clk_sys);
            clearSums <= 1'b0;
            cnt = 0;
            prevLvl = segLevel[1];
            repeat (WIN)
            begin
                @(negedge clk_sys);
                if (segLevel[1] !== prevLvl) cnt++;
                prevLvl = segLevel[1];
            end
            e = expChanges(m[1], m[0]);
            `CHECK(cnt >= e - 1 && cnt <= e + 1, 1'b1)
            `CHECK(fullCnt[0][0] > 0, 1'b1)
            `CHECK(fullCnt[1][0], 0)
            `CHECK(dcSum[0][0] < 100 && dcSum[0][0] > -100, 1'b1)
            `CHECK(dcSum[1][1] < 100 && dcSum[1][1] > -100, 1'b1)
        end
        axiWrite(`REG_DMEM_OFS, 32'h7, resp);
        axiRead(`REG_DMEM_OFS, rd, resp);
        `CHECK(rd, 32'h3)
        @(posedge clk_sys);
        sleepMode <= 1'b1;
        settle(4);
        `CHECK(driveEn, 1'b1)
        `CHECK({comLevel, segLevel}, '0)
        axiRead(`REG_STATUS_OFS, rd, resp);
        `CHECK(rd[`STAT_RESET_BIT], 1'b1)
        wdtPulse();
        `CHECK(driveEn, 1'b1)
        @(posedge clk_sys);
        sleepMode <= 1'b0;
        idleMode <= 1'b1;
        wdtPulse();
        `CHECK(driveEn, 1'b1)
        axiRead(`REG_STATUS_OFS, rd, resp);
        `CHECK(rd[`STAT_RESET_BIT], 1'b0)
        idleMode <= 1'b0;
        mcuResetReq <= 1'b1;
        settle(3);
        `CHECK(driveEn, 1'b0)
        `CHECK({comLevel, segLevel}, '0)
        @(posedge clk_sys);
        mcuResetReq <= 1'b0;
        settle(3);
        wdtPulse();
        `CHECK(driveEn, 1'b0)
        axiWrite(`REG_CTRL_OFS, ctrlWord(1'b0, 1'b0, 1'b0), resp);
        settle(3);
        `CHECK({driveEn, pumpEn}, 2'h3)
        `CHECK({comLevel, segLevel}, '0)
        completeRun();
    end
endmodule // testbench
